//--- shared/exec_consts.vh
// Contract
// - Opcode 023c plus byte: AND immediate byte into condition code byte.
// - Each zero immediate bit 4..0 clears X, N, Z, V, C; ones keep.
// - Opcode 027c plus word: AND whole word into the status word.
// - Status word AND only in supervisor state; otherwise trap, no change.
// - Shifts load carry and extend with the last bit shifted out.
// - Immediate count 1..7, zero means 8; register count is modulo 64.
// - Memory shift moves exactly one bit, word size only.
// - Left shift feeds zeros in, top bit out to carry and extend.
// - Right shift replicates sign, bottom bit out to carry and extend.
// - Overflow set if the top bit changes at any step, else cleared.
// - Count zero keeps extend and clears carry.
// - Negative from result top bit; zero when sized result is zero.
// - Register shift: 1110, count, direction, size, source bit, 00, register.
// - Size 00 byte, 01 word, 10 long.
// - Memory shift accepts only memory alterable modes; others rejected.
// - Taken branch: address plus two plus displacement; else fall through.
// - Displacement 00 uses next word; ff uses next long word.
// - Condition codes 0010 to 1111 select the fourteen tests.
// - Branch word: 0110, condition in 11-8, displacement in 7-0.
`ifndef EXEC_CONSTS_VH
`define EXEC_CONSTS_VH
`define OFF_OPCODE    8'h00
`define OFF_EXT       8'h04
`define OFF_OPERAND   8'h08
`define OFF_COUNT     8'h0c
`define OFF_PSW       8'h10
`define OFF_PROG_CNT  8'h14
`define OFF_RESULT    8'h18
`define OFF_STATUS    8'h1c
`define RESP_OKAY     2'b00
`define RESP_SLVERR   2'b10
`define OP_AND_CCB    16'h023c
`define OP_AND_PSW    16'h027c
`define GRP_SHIFT     4'he
`define GRP_BRANCH    4'h6
`define MEM_SHIFT_TOP 7'h70
`define SZ_BYTE       2'b00
`define SZ_WORD       2'b01
`define SZ_LONG       2'b10
`define SZ_MEM        2'b11
`define FLG_C         0
`define FLG_V         1
`define FLG_Z         2
`define FLG_N         3
`define FLG_X         4
`define PSW_SUPER     13
`define PSW_RESET     16'h2700
`define ST_DONE       0
`define ST_TRAP       1
`define ST_ILLEGAL    2
`define ST_TAKEN      3
`define IMM_CNT_ZERO  6'h08
`define MEM_CNT       6'h01
`define SHIFT_STEPS   64
`define DISP_WORD     8'h00
`define DISP_LONG     8'hff
`define LEN_BASE      32'h00000002
`define LEN_EXT_W     32'h00000004
`define LEN_EXT_L     32'h00000006
`define EA_IND        3'h2
`define EA_IDX        3'h6
`define EA_ABS        3'h7
`define EA_ABS_LONG   3'h1
`define CND_TRUE      4'h0
`define CND_FALSE     4'h1
`define CND_HIGH      4'h2
`define CND_LOW_SAME  4'h3
`define CND_C_CLR     4'h4
`define CND_C_SET     4'h5
`define CND_NOT_EQUAL 4'h6
`define CND_EQUAL     4'h7
`define CND_V_CLR     4'h8
`define CND_V_SET     4'h9
`define CND_PLUS      4'ha
`define CND_MINUS     4'hb
`define CND_GR_EQ     4'hc
`define CND_LESS      4'hd
`define CND_GREATER   4'he
`define CND_LESS_EQ   4'hf
`endif

//--- test/flag_and_shift_branch_exec_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "exec_consts.vh"
module flag_and_shift_branch_exec_checker (
  input wire logic        CLOCK,
  input wire logic        RESET_N,
  input wire logic [7:0]  AWADDR,
  input wire logic        AWVALID,
  input wire logic        AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0]  WSTRB,
  input wire logic        WVALID,
  input wire logic        WREADY,
  input wire logic [1:0]  BRESP,
  input wire logic        BVALID,
  input wire logic        BREADY,
  input wire logic [7:0]  ARADDR,
  input wire logic        ARVALID,
  input wire logic        ARREADY,
  input wire logic [31:0] RDATA,
  input wire logic [1:0]  RRESP,
  input wire logic        RVALID,
  input wire logic        RREADY
);
  // ****
  // Bus checks
  // ****
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);
  sequence aw_w_taken;
    AWVALID && AWREADY && WVALID && WREADY && !BVALID;
  endsequence
  sequence b_wait;
    BVALID && !BREADY;
  endsequence
  AST_B_AFTER: assert property (aw_w_taken |-> ##[1:2] BVALID)
    else $error("write response late");
  AST_B_HOLD: assert property (b_wait |=> BVALID && $stable(BRESP))
    else $error("write response dropped");
  AST_B_CODE: assert property (BVALID |-> BRESP == `RESP_OKAY || BRESP == `RESP_SLVERR)
    else $error("bad write response code");
  AST_R_ANS: assert property (ARVALID && ARREADY |=> RVALID)
    else $error("read answer late");
  AST_R_HOLD: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA) && $stable(RRESP))
    else $error("read data not held");
  AST_R_DONE: assert property (RVALID && RREADY |=> !RVALID)
    else $error("read valid stuck");
  AST_AR_BLOCK: assert property (RVALID |-> !ARREADY)
    else $error("read accepted while busy");
  AST_R_ERR: assert property (RVALID && RRESP == `RESP_SLVERR |-> RDATA == 32'h0)
    else $error("refused read carries data");
  AST_RST: assert property ($rose(RESET_N) |-> !BVALID && !RVALID && RDATA == 32'h0)
    else $error("bus not idle after reset");
endmodule // flag_and_shift_branch_exec_checker
`default_nettype wire

//--- test/flag_and_shift_branch_exec_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "exec_consts.vh"
module flag_and_shift_branch_exec_tb;
  // ****
  // Bench
  // ****
  logic        CLOCK = 0;
  logic        RESET_N = 0;
  logic [7:0]  AWADDR = 0;
  logic [7:0]  ARADDR = 0;
  logic        AWVALID = 0;
  logic        WVALID = 0;
  logic        BREADY = 0;
  logic        ARVALID = 0;
  logic        RREADY = 0;
  logic [31:0] WDATA = 0;
  logic [3:0]  WSTRB = 4'hf;
  wire         AWREADY, WREADY, BVALID, ARREADY, RVALID;
  wire  [1:0]  BRESP, RRESP;
  wire  [31:0] RDATA;
  int          n_mismatch = 0;
  int          total_checks = 0;
  logic [31:0] d;

  always #12.5 CLOCK = ~CLOCK;
  flag_and_shift_branch_exec flag_and_shift_branch_exec_inst (.*);

  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask

  // Holds each channel until its own ready; no cycle count assumed
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    @(posedge CLOCK);
    AWADDR <= a;
    WDATA <= v;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    forever begin
      @(posedge CLOCK);
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
      if (BVALID) break;
    end
    BREADY <= 1'b0;
    chk("bresp", {30'h0, BRESP}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] v);
    @(posedge CLOCK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    forever begin
      @(posedge CLOCK);
      if (ARREADY) ARVALID <= 1'b0;
      if (RVALID) break;
    end
    RREADY <= 1'b0;
    v = RDATA;
    chk("rresp", {30'h0, RRESP}, {30'h0, er});
  endtask

  task automatic ck(input logic [7:0] a, input logic [31:0] exp, input string nm);
    rd(a, `RESP_OKAY, d);
    chk(nm, d, exp);
  endtask

  task automatic go(input logic [15:0] op);
    wr(`OFF_OPCODE, {16'h0, op}, `RESP_OKAY);
  endtask

  task automatic t_bus;
    ck(`OFF_PSW, {16'h0, `PSW_RESET}, "psw_reset");
    wr(8'h20, 32'h1, `RESP_SLVERR);
    wr(`OFF_RESULT, 32'h1, `RESP_SLVERR);
    rd(8'h20, `RESP_SLVERR, d);
    chk("unmapped", d, 32'h0);
  endtask

  task automatic t_and;
    wr(`OFF_PSW, 32'h271f, `RESP_OKAY);
    wr(`OFF_PROG_CNT, 32'h100, `RESP_OKAY);
    wr(`OFF_EXT, 32'hea, `RESP_OKAY);
    go(`OP_AND_CCB);
    ck(`OFF_PSW, 32'h270a, "and_ccb");
    wr(`OFF_EXT, 32'ha5f3, `RESP_OKAY);
    go(`OP_AND_PSW);
    ck(`OFF_PSW, 32'h2502, "and_psw");
    // Outside supervisor state the word must survive
    wr(`OFF_PSW, 32'h001f, `RESP_OKAY);
    go(`OP_AND_PSW);
    ck(`OFF_PSW, 32'h001f, "user_psw");
    rd(`OFF_STATUS, `RESP_OKAY, d);
    chk("trap", {31'h0, d[`ST_TRAP]}, 32'h1);
  endtask

  task automatic t_shift;
    logic [15:0] op [6] = '{16'he100, 16'he260, 16'he3a0, 16'he1d0, 16'he600, 16'he3a0};
    logic [31:0] opd [6] = '{32'h81, 32'hffff8001, 32'h80000000, 32'h14000,
                             32'h12345690, 32'h80000000};
    logic [31:0] res [6] = '{32'h0, 32'hffffc000, 32'h80000000, 32'h18000,
                             32'h123456f2, 32'h0};
    logic [31:0] cnt [6] = '{32'h0, 32'h41, 32'h40, 32'h0, 32'h0, 32'h1};
    logic [31:0] psw [6] = '{32'h2700, 32'h2700, 32'h2711, 32'h2711, 32'h2711, 32'h2700};
    logic [4:0]  flg [6] = '{5'h17, 5'h19, 5'h18, 5'h0a, 5'h08, 5'h17};
    for (int i = 0; i < 6; i++) begin
      wr(`OFF_PSW, psw[i], `RESP_OKAY);
      wr(`OFF_OPERAND, opd[i], `RESP_OKAY);
      wr(`OFF_COUNT, cnt[i], `RESP_OKAY);
      go(op[i]);
      ck(`OFF_RESULT, res[i], "result");
      rd(`OFF_PSW, `RESP_OKAY, d);
      chk("flags", {27'h0, d[4:0]}, {27'h0, flg[i]});
    end
  endtask

  task automatic t_illegal;
    logic [15:0] op [7] = '{16'he1c0, 16'he1fc, 16'he1fa, 16'he108, 16'he1f9, 16'he1e8,
                            16'he1c8};
    logic        bad [7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
    for (int i = 0; i < 7; i++) begin
      go(op[i]);
      rd(`OFF_STATUS, `RESP_OKAY, d);
      chk("illegal", {31'h0, d[`ST_ILLEGAL]}, {31'h0, bad[i]});
    end
  endtask

  task automatic t_branch;
    logic [4:0]  fl [3] = '{5'h00, 5'h1f, 5'h08};
    logic [15:0] msk [3] = '{16'h5555, 16'h9aa9, 16'ha955};
    logic [15:0] op [5] = '{16'h6200, 16'h62ff, 16'h6300, 16'h63ff, 16'h6210};
    logic [31:0] ext [5] = '{32'hfff0, 32'h10000, 32'h1234, 32'h1234, 32'h0};
    logic [31:0] pc [5] = '{32'h0ff2, 32'h11002, 32'h1004, 32'h1006, 32'h1012};
    for (int i = 0; i < 3; i++) begin
      wr(`OFF_PSW, {24'h000027, 3'h0, fl[i]}, `RESP_OKAY);
      for (int c = 0; c < 16; c++) begin
        wr(`OFF_PROG_CNT, 32'h1000, `RESP_OKAY);
        go({4'h6, c[3:0], 8'hfe});
        ck(`OFF_PROG_CNT, msk[i][c] ? 32'h1000 : 32'h1002, "bcc_pc");
        rd(`OFF_STATUS, `RESP_OKAY, d);
        chk("taken", {31'h0, d[`ST_TAKEN]}, {31'h0, msk[i][c]});
      end
    end
    wr(`OFF_PSW, 32'h2700, `RESP_OKAY);
    for (int i = 0; i < 5; i++) begin
      wr(`OFF_PROG_CNT, 32'h1000, `RESP_OKAY);
      wr(`OFF_EXT, ext[i], `RESP_OKAY);
      go(op[i]);
      ck(`OFF_PROG_CNT, pc[i], "disp_pc");
    end
  endtask

  // Generous bound; the full run needs only about a thousand cycles
  initial begin
    #(25 * 40000);
    n_mismatch++;
    test_done;
  end

  initial begin
    repeat (16) @(posedge CLOCK);
    RESET_N <= 1'b1;
    t_bus;
    t_and;
    t_shift;
    t_illegal;
    t_branch;
    test_done;
  end
endmodule // flag_and_shift_branch_exec_tb

bind flag_and_shift_branch_exec flag_and_shift_branch_exec_checker
  flag_and_shift_branch_exec_checker_inst (.*);
`default_nettype wire

//--- verilog/arith_shifter.v
`timescale 1ns/1ps
`default_nettype none
`include "exec_consts.vh"
module arith_shifter (
  input  wire [31:0] operand,
  input  wire [5:0]  count,
  input  wire        left,
  input  wire [1:0]  size,
  output reg  [31:0] result,
  output reg         carry,
  output reg         ovf,
  output reg         neg,
  output reg         zero
);
  reg [31:0] val;
  reg [4:0]  top;
  reg        old;
  integer    i;

  function [31:0] size_mask;
    input [1:0] sz;
    begin
      if (sz == `SZ_BYTE) size_mask = 32'h000000ff;
      else if (sz == `SZ_LONG) size_mask = 32'hffffffff;
      else size_mask = 32'h0000ffff;
    end
  endfunction

  always @* begin
    val = operand & size_mask(size);
    top = (size == `SZ_BYTE) ? 5'h07 : ((size == `SZ_LONG) ? 5'h1f : 5'h0f);
    old = 1'b0;
    carry = 1'b0;
    ovf = 1'b0;
    // Unrolled ladder: one cycle per shift at the cost of depth
    for (i = 0; i < `SHIFT_STEPS; i = i + 1) begin
      if (i < count) begin
        old = val[top];
        if (left) begin
          carry = old;
          val = (val << 1) & size_mask(size);
        end else begin
          carry = val[0];
          val = (val >> 1) | ({31'h0, old} << top);
        end
        if (val[top] != old) ovf = 1'b1;
      end
    end
    result = (operand & ~size_mask(size)) | val;
    neg = val[top];
    zero = (val == 32'h0);
  end
endmodule // arith_shifter
`default_nettype wire

//--- verilog/branch_condition.v
`timescale 1ns/1ps
`default_nettype none
`include "exec_consts.vh"
module branch_condition (
  input  wire [3:0] cond,
  input  wire [4:0] flags,
  output reg        taken
);
  wire c = flags[`FLG_C];
  wire v = flags[`FLG_V];
  wire z = flags[`FLG_Z];
  wire n = flags[`FLG_N];

  always @* begin
    case (cond)
      `CND_TRUE:      taken = 1'b1;
      `CND_FALSE:     taken = 1'b0;
      `CND_HIGH:      taken = ~c & ~z;
      `CND_LOW_SAME:  taken = c | z;
      `CND_C_CLR:     taken = ~c;
      `CND_C_SET:     taken = c;
      `CND_NOT_EQUAL: taken = ~z;
      `CND_EQUAL:     taken = z;
      `CND_V_CLR:     taken = ~v;
      `CND_V_SET:     taken = v;
      `CND_PLUS:      taken = ~n;
      `CND_MINUS:     taken = n;
      `CND_GR_EQ:     taken = ~(n ^ v);
      `CND_LESS:      taken = n ^ v;
      `CND_GREATER:   taken = ~(n ^ v) & ~z;
      default:        taken = (n ^ v) | z;
    endcase
  end
endmodule // branch_condition
`default_nettype wire

//--- verilog/flag_and_shift_branch_exec.v
`timescale 1ns/1ps
`default_nettype none
`include "exec_consts.vh"
module flag_and_shift_branch_exec (
  input  wire        CLOCK,
  input  wire        RESET_N,
  input  wire [7:0]  AWADDR,
  input  wire        AWVALID,
  output wire        AWREADY,
  input  wire [31:0] WDATA,
  input  wire [3:0]  WSTRB,
  input  wire        WVALID,
  output wire        WREADY,
  output reg  [1:0]  BRESP,
  output reg         BVALID,
  input  wire        BREADY,
  input  wire [7:0]  ARADDR,
  input  wire        ARVALID,
  output wire        ARREADY,
  output reg  [31:0] RDATA,
  output reg  [1:0]  RRESP,
  output reg         RVALID,
  input  wire        RREADY
);
  // ****************************************
  // Register state
  // ****************************************
  reg  [15:0] opcode_r;
  reg  [31:0] ext_r;
  reg  [31:0] operand_r;
  reg  [31:0] count_src_r;
  reg  [15:0] psw_r;
  reg  [31:0] prog_cnt_r;
  reg  [31:0] result_r;
  reg  [3:0]  status_r;
  reg         start_r;
  reg  [7:0]  aw_addr_r;
  reg         aw_got_r;
  reg  [31:0] w_data_r;
  reg  [3:0]  w_strb_r;
  reg         w_got_r;

  reg  [15:0] psw_nxt;
  reg  [31:0] prog_cnt_nxt;
  reg  [31:0] result_nxt;
  reg  [3:0]  status_nxt;
  reg  [31:0] rdata_nxt;
  reg  [1:0]  rresp_nxt;
  reg         wr_ok;
  reg         we_opcode;
  reg         we_ext;
  reg         we_operand;
  reg         we_count;
  reg         we_psw;
  reg         we_prog_cnt;

  // ****************************************
  // Helper functions
  // ****************************************
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (strb[k]) merge[k*8 +: 8] = nw[k*8 +: 8];
      end
    end
  endfunction

  // Upper lanes ignored for the 16-bit registers
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    begin
      merge16 = old;
      if (strb[0]) merge16[7:0] = nw[7:0];
      if (strb[1]) merge16[15:8] = nw[15:8];
    end
  endfunction

  function ea_ok;
    input [2:0] mode;
    input [2:0] rg;
    begin
      if (mode >= `EA_IND && mode <= `EA_IDX) ea_ok = 1'b1;
      else if (mode == `EA_ABS && rg <= `EA_ABS_LONG) ea_ok = 1'b1;
      else ea_ok = 1'b0;
    end
  endfunction

  function mapped;
    input [7:0] a;
    begin
      mapped = (a[1:0] == 2'b00) && (a <= `OFF_STATUS);
    end
  endfunction

  // ****************************************
  // Instruction decode
  // ****************************************
  wire is_and_ccb = (opcode_r == `OP_AND_CCB);
  wire is_and_psw = (opcode_r == `OP_AND_PSW);
  wire is_reg_shift = (opcode_r[15:12] == `GRP_SHIFT) &&
                      (opcode_r[7:6] != `SZ_MEM) &&
                      (opcode_r[4:3] == 2'b00);
  wire is_mem_shift = (opcode_r[15:9] == `MEM_SHIFT_TOP) &&
                      (opcode_r[7:6] == `SZ_MEM);
  wire mem_ea_ok = ea_ok(opcode_r[5:3], opcode_r[2:0]);
  wire shift_ok = is_reg_shift || (is_mem_shift && mem_ea_ok);
  wire is_branch = (opcode_r[15:12] == `GRP_BRANCH);

  wire [5:0] imm_cnt = (opcode_r[11:9] == 3'h0) ? `IMM_CNT_ZERO
                                                : {3'h0, opcode_r[11:9]};
  wire [5:0] reg_cnt = opcode_r[5] ? count_src_r[5:0] : imm_cnt;
  wire [5:0] sh_cnt = is_mem_shift ? `MEM_CNT : reg_cnt;
  wire [1:0] sh_size = is_mem_shift ? `SZ_WORD : opcode_r[7:6];

  wire [31:0] sh_res;
  wire        sh_c;
  wire        sh_v;
  wire        sh_n;
  wire        sh_z;

  arith_shifter arith_shifter_inst (
    .operand (operand_r),
    .count   (sh_cnt),
    .left    (opcode_r[8]),
    .size    (sh_size),
    .result  (sh_res),
    .carry   (sh_c),
    .ovf     (sh_v),
    .neg     (sh_n),
    .zero    (sh_z)
  );

  wire cond_true;

  branch_condition branch_condition_inst (
    .cond  (opcode_r[11:8]),
    .flags (psw_r[4:0]),
    .taken (cond_true)
  );

  wire [7:0]  disp8 = opcode_r[7:0];
  wire [31:0] disp = (disp8 == `DISP_WORD) ? {{16{ext_r[15]}}, ext_r[15:0]} :
                     (disp8 == `DISP_LONG) ? ext_r :
                     {{24{disp8[7]}}, disp8};
  wire [31:0] br_len = (disp8 == `DISP_WORD) ? `LEN_EXT_W :
                       (disp8 == `DISP_LONG) ? `LEN_EXT_L : `LEN_BASE;

  // ****************************************
  // Execute
  // ****************************************
  always @* begin
    psw_nxt = psw_r;
    prog_cnt_nxt = prog_cnt_r;
    result_nxt = result_r;
    status_nxt = 4'h0;
    status_nxt[`ST_DONE] = 1'b1;
    if (is_and_ccb) begin
      psw_nxt[7:0] = psw_r[7:0] & ext_r[7:0];
      prog_cnt_nxt = prog_cnt_r + `LEN_EXT_W;
    end else if (is_and_psw) begin
      if (psw_r[`PSW_SUPER]) begin
        psw_nxt = psw_r & ext_r[15:0];
        prog_cnt_nxt = prog_cnt_r + `LEN_EXT_W;
      end else begin
        status_nxt[`ST_TRAP] = 1'b1;
      end
    end else if (shift_ok) begin
      result_nxt = sh_res;
      psw_nxt[`FLG_C] = sh_c;
      if (sh_cnt != 6'h00) psw_nxt[`FLG_X] = sh_c;
      psw_nxt[`FLG_V] = sh_v;
      psw_nxt[`FLG_N] = sh_n;
      psw_nxt[`FLG_Z] = sh_z;
      prog_cnt_nxt = prog_cnt_r + `LEN_BASE;
    end else if (is_branch) begin
      status_nxt[`ST_TAKEN] = cond_true;
      if (cond_true) prog_cnt_nxt = prog_cnt_r + `LEN_BASE + disp;
      else prog_cnt_nxt = prog_cnt_r + br_len;
    end else begin
      // Rejected forms leave PSW, program counter and result alone
      status_nxt[`ST_ILLEGAL] = 1'b1;
    end
  end

  // ****************************************
  // Bus slave
  // ****************************************
  assign AWREADY = ~aw_got_r;
  assign WREADY  = ~w_got_r;
  assign ARREADY = ~RVALID;

  wire wr_do = aw_got_r & w_got_r & ~BVALID;
  wire rd_do = ARVALID & ~RVALID;

  always @* begin
    wr_ok = mapped(aw_addr_r) && (aw_addr_r != `OFF_RESULT) &&
            (aw_addr_r != `OFF_STATUS);
    rresp_nxt = `RESP_OKAY;
    rdata_nxt = 32'h0;
    if (ARADDR == `OFF_OPCODE) rdata_nxt = {16'h0, opcode_r};
    else if (ARADDR == `OFF_EXT) rdata_nxt = ext_r;
    else if (ARADDR == `OFF_OPERAND) rdata_nxt = operand_r;
    else if (ARADDR == `OFF_COUNT) rdata_nxt = count_src_r;
    else if (ARADDR == `OFF_PSW) rdata_nxt = {16'h0, psw_r};
    else if (ARADDR == `OFF_PROG_CNT) rdata_nxt = prog_cnt_r;
    else if (ARADDR == `OFF_RESULT) rdata_nxt = result_r;
    else if (ARADDR == `OFF_STATUS) rdata_nxt = {28'h0, status_r};
    else rresp_nxt = `RESP_SLVERR;
  end

  always @(posedge CLOCK) begin
    if (!RESET_N) begin
      aw_got_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_got_r <= 1'b0;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
      BVALID <= 1'b0;
      BRESP <= `RESP_OKAY;
    end else begin
      if (AWVALID && !aw_got_r) begin
        aw_got_r <= 1'b1;
        aw_addr_r <= AWADDR;
      end else if (wr_do) begin
        aw_got_r <= 1'b0;
      end
      if (WVALID && !w_got_r) begin
        w_got_r <= 1'b1;
        w_data_r <= WDATA;
        w_strb_r <= WSTRB;
      end else if (wr_do) begin
        w_got_r <= 1'b0;
      end
      if (wr_do) begin
        BVALID <= 1'b1;
        BRESP <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (BREADY) begin
        BVALID <= 1'b0;
      end
    end
  end

  // ****************************************
  // Read channel
  // ****************************************
  always @(posedge CLOCK) begin
    if (!RESET_N) begin
      RVALID <= 1'b0;
      RRESP <= `RESP_OKAY;
      RDATA <= 32'h0;
    end else begin
      if (rd_do) begin
        RVALID <= 1'b1;
        RDATA <= rdata_nxt;
        RRESP <= rresp_nxt;
      end else if (RREADY) begin
        RVALID <= 1'b0;
      end
    end
  end

  // ****************************************
  // Write strobes
  // ****************************************
  // One strobe per cycle; refused writes raise none
  always @* begin
    we_opcode = 1'b0;
    we_ext = 1'b0;
    we_operand = 1'b0;
    we_count = 1'b0;
    we_psw = 1'b0;
    we_prog_cnt = 1'b0;
    if (wr_do && wr_ok) begin
      if (aw_addr_r == `OFF_OPCODE) we_opcode = 1'b1;
      else if (aw_addr_r == `OFF_EXT) we_ext = 1'b1;
      else if (aw_addr_r == `OFF_OPERAND) we_operand = 1'b1;
      else if (aw_addr_r == `OFF_COUNT) we_count = 1'b1;
      else if (aw_addr_r == `OFF_PSW) we_psw = 1'b1;
      else if (aw_addr_r == `OFF_PROG_CNT) we_prog_cnt = 1'b1;
    end
  end

  // ****************************************
  // Architectural state
  // ****************************************
  // Execution and bus writes never meet: a write needs BVALID low,
  // and the write that starts execution raised it.
  always @(posedge CLOCK) begin
    if (!RESET_N) begin
      opcode_r <= 16'h0;
      ext_r <= 32'h0;
      operand_r <= 32'h0;
      count_src_r <= 32'h0;
      psw_r <= `PSW_RESET;
      prog_cnt_r <= 32'h0;
      result_r <= 32'h0;
      status_r <= 4'h0;
      start_r <= 1'b0;
    end else begin
      start_r <= 1'b0;
      if (start_r) begin
        psw_r <= psw_nxt;
        prog_cnt_r <= prog_cnt_nxt;
        result_r <= result_nxt;
        status_r <= status_nxt;
      end else if (we_opcode) begin
        opcode_r <= merge16(opcode_r, w_data_r, w_strb_r);
        start_r <= 1'b1;
        status_r <= 4'h0;
      end else if (we_ext) begin
        ext_r <= merge(ext_r, w_data_r, w_strb_r);
      end else if (we_operand) begin
        operand_r <= merge(operand_r, w_data_r, w_strb_r);
      end else if (we_count) begin
        count_src_r <= merge(count_src_r, w_data_r, w_strb_r);
      end else if (we_psw) begin
        psw_r <= merge16(psw_r, w_data_r, w_strb_r);
      end else if (we_prog_cnt) begin
        prog_cnt_r <= merge(prog_cnt_r, w_data_r, w_strb_r);
      end
    end
  end
endmodule // flag_and_shift_branch_exec
`default_nettype wire
